// ---- rtl/uart_frame_loop_config.v ----
// serial transceiver with frame format, loop routing and apb registers
//
// Contract
// - loop select clear gives full duplex on separate receive and transmit pins.
// - loop select set feeds the transmitter output, or in single wire the transmit pin, to the receiver and ignores the receive pin.
// - wait-mode stop clear keeps the transceiver running in cpu wait, set freezes it.
// - receiver source select matters only while loop select is set.
// - loop set with source clear is internal loopback without the receive pin.
// - loop set with source set is single wire: the transmit pin feeds the receiver.
// - eight-bit mode frames start, eight data bits lsb first, then stop.
// - nine-bit mode frames start, eight data bits lsb first, ninth bit, then stop.
// - wakeup method selects idle-line wakeup at 0 and address-mark wakeup at 1.
// - idle is declared after 10 or 11 bit times high, by character length.
// - idle type 0 counts from after the start bit, 1 only from after the stop bit.
// - parity enable generates parity on transmit and checks on receive in the msb.
// - parity type 0 is even and 1 is odd, counted over the whole character.
// - the enable register is read/write over eight bits holding four fields, reset to 0; a wakeup clears its wakeup bit.
// - in single wire a direction bit decides if the transmit pin drives or listens.
`timescale 1ns/1ps
`include "uart_frame_loop_config_regs.vh"
module uart_frame_loop_config #(
  parameter ADDR_W = 8,
  parameter DW     = 9
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire [ADDR_W-1:0] paddr,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              cpu_wait,
  input  wire              rx_pin,
  input  wire              tx_in,
  output reg               tx_out,
  output reg               tx_oe
);
  localparam T_IDLE = 2'b00;
  localparam T_START = 2'b01;
  localparam T_DATA = 2'b10;
  localparam T_STOP = 2'b11;

  reg [7:0]    frame_format_control;
  reg [7:0]    enable_interrupt_control;
  reg [15:0]   baud_div;
  reg          single_wire_direction;
  reg [8:0]    rx_data;
  reg          rx_full;
  reg          idle_flag;
  reg          perr_flag;
  reg          ferr_flag;
  reg          ovr_flag;
  reg          rx_s1;
  reg          rx_s2;
  reg          txin_s1;
  reg          txin_s2;
  reg [DW-1:0] buf_mem [0:1];
  reg          buf_wp;
  reg          buf_rp;
  reg [1:0]    buf_cnt;
  reg [1:0]    t_state;
  reg [15:0]   t_cnt;
  reg [3:0]    t_idx;
  reg [8:0]    t_sh;
  reg [1:0]    r_state;
  reg [15:0]   r_cnt;
  reg [3:0]    r_idx;
  reg [8:0]    r_sh;
  reg [15:0]   b_cnt;
  reg [3:0]    i_cnt;

  wire loop_select  = frame_format_control[`F_LOOP];
  wire wait_stop    = frame_format_control[`F_WAITSTOP];
  wire src_select   = frame_format_control[`F_SRC];
  wire nine         = frame_format_control[`F_NINE];
  wire wake_method  = frame_format_control[`F_WAKE];
  wire idle_type    = frame_format_control[`F_IDLETYPE];
  wire parity_en    = frame_format_control[`F_PARITY_EN];
  wire parity_type  = frame_format_control[`F_PARITY_T];
  wire tx_en        = enable_interrupt_control[`E_TX_EN];
  wire rx_en        = enable_interrupt_control[`E_RX_EN];
  wire receiver_wakeup_control          = enable_interrupt_control[`E_WAKEUP];
  wire brk          = enable_interrupt_control[`E_BREAK];

  function [8:0] add_parity;
    input [8:0] d;
    input       n9;
    input       pe;
    input       pt;
    reg         p;
    begin
      p = (n9 ? ^d[7:0] : ^d[6:0]) ^ pt;
      add_parity = d;
      if (pe && n9)
        add_parity[8] = p;
      else if (pe)
        add_parity[7] = p;
    end
  endfunction

  function parity_bad;
    input [8:0] d;
    input       n9;
    input       pe;
    input       pt;
    begin
      parity_bad = pe && ((n9 ? ^d : ^d[7:0]) != pt);
    end
  endfunction

  // transceiver halts while cpu waits and wait-mode stop is set
  wire run = ~(wait_stop & cpu_wait) && (baud_div != 16'h0000);
  wire single_wire = loop_select & src_select;
  wire [3:0] last_bit = nine ? `LAST_BIT_9 : `LAST_BIT_8;
  wire [3:0] idle_lim = nine ? `IDLE_BITS_9 : `IDLE_BITS_8;

  reg rx_line;
  always @* begin
    if (!loop_select)
      rx_line = rx_s2;
    else if (!src_select)
      rx_line = tx_out;
    else if (tx_oe)
      rx_line = tx_out;
    else
      rx_line = txin_s2;
  end

  // apb decode
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire hit_frame = (paddr == `OFS_FRAME);
  wire hit_enable = (paddr == `OFS_ENABLE);
  wire hit_data = (paddr == `OFS_DATA);
  wire hit_status = (paddr == `OFS_STATUS);
  wire hit_baud = (paddr == `OFS_BAUD);
  wire hit_line = (paddr == `OFS_LINE);
  wire mapped = hit_frame | hit_enable | hit_data | hit_status |
                hit_baud | hit_line;

  wire buf_full = (buf_cnt == 2'b10);
  wire buf_empty = (buf_cnt == 2'b00);
  wire push = wr & hit_data & ~buf_full;
  wire pop = run & tx_en & (t_state == T_IDLE) & ~buf_empty & ~brk;

  wire r_tick = run & (r_cnt == 16'h0000) & (r_state != T_IDLE);
  wire r_done = r_tick & (r_state == T_STOP);
  wire [8:0] r_char = nine ? r_sh : {1'b0, r_sh[8:1]};
  wire r_msb = nine ? r_sh[8] : r_sh[8];
  wire b_tick = run & (b_cnt == 16'h0000);
  wire idle_hit = b_tick & rx_line & ~(idle_type & (r_state != T_IDLE)) &
                  (i_cnt == idle_lim - 4'h1);
  // address-mark wakeup accepts the waking character
  wire mark_wake = r_done & receiver_wakeup_control & wake_method & r_msb;
  wire idle_wake = idle_hit & receiver_wakeup_control & ~wake_method;
  wire accept = r_done & (~receiver_wakeup_control | mark_wake);

  wire [7:0] status = {1'b0, ovr_flag, ferr_flag, perr_flag, idle_flag,
                       rx_full, (t_state == T_IDLE) & buf_empty, ~buf_full};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      txin_s1 <= 1'b1;
      txin_s2 <= 1'b1;
    end else begin
      rx_s1 <= rx_pin;
      rx_s2 <= rx_s1;
      txin_s1 <= tx_in;
      txin_s2 <= txin_s1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata <= 32'h00000000;
      if (psel & penable & ~pready & ~pwrite) begin
        if (hit_frame)
          prdata <= {24'h000000, frame_format_control};
        if (hit_enable)
          prdata <= {24'h000000, enable_interrupt_control};
        if (hit_data)
          prdata <= {23'h0, rx_data};
        if (hit_status)
          prdata <= {24'h000000, status};
        if (hit_baud)
          prdata <= {16'h0000, baud_div};
        if (hit_line)
          prdata <= {31'h0, single_wire_direction};
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_format_control <= `RST_FRAME;
      enable_interrupt_control <= `RST_ENABLE;
      baud_div <= `RST_BAUD;
      single_wire_direction <= `RST_LINE;
    end else begin
      if (wr & hit_frame)
        frame_format_control <= pwdata[7:0];
      if (wr & hit_enable)
        enable_interrupt_control <= pwdata[7:0];
      else if (mark_wake | idle_wake)
        enable_interrupt_control[`E_WAKEUP] <= 1'b0;
      if (wr & hit_baud)
        baud_div <= pwdata[15:0];
      if (wr & hit_line)
        single_wire_direction <= pwdata[0];
    end
  end

  // two-entry transmit buffer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_cnt <= 2'b00;
      buf_mem[0] <= {DW{1'b0}};
      buf_mem[1] <= {DW{1'b0}};
    end else begin
      if (push) begin
        buf_mem[buf_wp] <= pwdata[DW-1:0];
        buf_wp <= ~buf_wp;
      end
      if (pop)
        buf_rp <= ~buf_rp;
      if (push & ~pop)
        buf_cnt <= buf_cnt + 2'b01;
      else if (pop & ~push)
        buf_cnt <= buf_cnt - 2'b01;
    end
  end

  // transmitter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_state <= T_IDLE;
      t_cnt <= 16'h0000;
      t_idx <= 4'h0;
      t_sh <= 9'h000;
      tx_out <= 1'b1;
      tx_oe <= 1'b0;
    end else begin
      tx_oe <= tx_en & ~(single_wire & ~single_wire_direction);
      if (run) begin
        if (t_state != T_IDLE)
          t_cnt <= (t_cnt == 16'h0000) ? baud_div - 16'h0001
                                        : t_cnt - 16'h0001;
        case (t_state)
          T_IDLE: begin
            tx_out <= ~(brk & tx_en);
            if (pop) begin
              t_sh <= add_parity(buf_mem[buf_rp], nine, parity_en,
                                 parity_type);
              t_cnt <= baud_div - 16'h0001;
              tx_out <= 1'b0;
              t_state <= T_START;
            end
          end
          T_START: begin
            if (t_cnt == 16'h0000) begin
              tx_out <= t_sh[0];
              t_sh <= {1'b0, t_sh[8:1]};
              t_idx <= 4'h0;
              t_state <= T_DATA;
            end
          end
          T_DATA: begin
            if (t_cnt == 16'h0000) begin
              t_idx <= t_idx + 4'h1;
              if (t_idx == last_bit) begin
                tx_out <= 1'b1;
                t_state <= T_STOP;
              end else begin
                tx_out <= t_sh[0];
                t_sh <= {1'b0, t_sh[8:1]};
              end
            end
          end
          default: begin
            if (t_cnt == 16'h0000)
              t_state <= T_IDLE;
          end
        endcase
      end
    end
  end

  // receiver
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_state <= T_IDLE;
      r_cnt <= 16'h0000;
      r_idx <= 4'h0;
      r_sh <= 9'h000;
    end else if (run) begin
      if (r_state != T_IDLE)
        r_cnt <= (r_cnt == 16'h0000) ? baud_div - 16'h0001
                                      : r_cnt - 16'h0001;
      case (r_state)
        T_IDLE: begin
          if (rx_en & ~rx_line) begin
            r_cnt <= {1'b0, baud_div[15:1]};
            r_state <= T_START;
          end
        end
        T_START: begin
          if (r_tick) begin
            r_idx <= 4'h0;
            r_state <= rx_line ? T_IDLE : T_DATA;
          end
        end
        T_DATA: begin
          if (r_tick) begin
            r_sh <= {rx_line, r_sh[8:1]};
            r_idx <= r_idx + 4'h1;
            if (r_idx == last_bit)
              r_state <= T_STOP;
          end
        end
        default: begin
          if (r_tick)
            r_state <= T_IDLE;
        end
      endcase
    end
  end

  // idle-line detector on free bit-time ticks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      b_cnt <= 16'h0000;
      i_cnt <= 4'h0;
    end else if (run) begin
      b_cnt <= (b_cnt == 16'h0000) ? baud_div - 16'h0001
                                    : b_cnt - 16'h0001;
      if (b_tick) begin
        if (~rx_line | (idle_type & (r_state != T_IDLE)))
          i_cnt <= 4'h0;
        else if (i_cnt != idle_lim)
          i_cnt <= i_cnt + 4'h1;
      end
    end
  end

  // receive flags: a setting event wins over a clear in the same cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data <= 9'h000;
      rx_full <= 1'b0;
      idle_flag <= 1'b0;
      perr_flag <= 1'b0;
      ferr_flag <= 1'b0;
      ovr_flag <= 1'b0;
    end else begin
      if (rd & hit_data)
        rx_full <= 1'b0;
      if (wr & hit_status) begin
        if (pwdata[`S_IDLE])
          idle_flag <= 1'b0;
        if (pwdata[`S_PERR])
          perr_flag <= 1'b0;
        if (pwdata[`S_FERR])
          ferr_flag <= 1'b0;
        if (pwdata[`S_OVR])
          ovr_flag <= 1'b0;
      end
      if (idle_hit & ~receiver_wakeup_control)
        idle_flag <= 1'b1;
      if (accept & rx_full & ~(rd & hit_data))
        ovr_flag <= 1'b1;
      else if (accept) begin
        rx_data <= r_char;
        rx_full <= 1'b1;
        if (parity_bad(r_char, nine, parity_en, parity_type))
          perr_flag <= 1'b1;
        if (~rx_line)
          ferr_flag <= 1'b1;
      end
    end
  end
endmodule // uart_frame_loop_config

// ---- rtl/uart_frame_loop_config_regs.vh ----
// register map, field positions and constants of the serial transceiver
`ifndef UART_FRAME_LOOP_CONFIG_REGS_VH
`define UART_FRAME_LOOP_CONFIG_REGS_VH
`define OFS_FRAME    8'h00
`define OFS_ENABLE   8'h04
`define OFS_DATA     8'h08
`define OFS_STATUS   8'h0C
`define OFS_BAUD     8'h10
`define OFS_LINE     8'h14
`define RST_FRAME    8'h00
`define RST_ENABLE   8'h00
`define RST_BAUD     16'h0010
`define RST_LINE     1'h0
// frame_format_control fields
`define F_LOOP       7
`define F_WAITSTOP   6
`define F_SRC        5
`define F_NINE       4
`define F_WAKE       3
`define F_IDLETYPE   2
`define F_PARITY_EN  1
`define F_PARITY_T   0
// enable_interrupt_control fields
`define E_TX_EN      3
`define E_RX_EN      2
`define E_WAKEUP     1
`define E_BREAK      0
// status fields
`define S_TXRDY      0
`define S_TXIDLE     1
`define S_RXFULL     2
`define S_IDLE       3
`define S_PERR       4
`define S_FERR       5
`define S_OVR        6
`define IDLE_BITS_8  4'hA
`define IDLE_BITS_9  4'hB
`define LAST_BIT_8   4'h7
`define LAST_BIT_9   4'h8
`endif

// ---- tb/remote_node.sv ----
// far serial node: sends one eight-bit character on its line
`timescale 1ns/1ps
module remote_node #(
  parameter BIT = 16
) (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       go,
  input  wire [7:0] ch,
  output reg        line
);
  reg [9:0] sh;
  reg [3:0] n;
  reg [4:0] t;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh   <= 10'h3FF;
      n    <= 4'h0;
      t    <= 5'h00;
      line <= 1'b1;
    end else if (go && n == 4'h0) begin
      sh <= {1'b1, ch, 1'b0};
      n  <= 4'hA;
      t  <= 5'h00;
    end else if (n != 4'h0) begin
      line <= sh[0];
      if (t == BIT - 1) begin
        t  <= 5'h00;
        sh <= {1'b1, sh[9:1]};
        n  <= n - 4'h1;
      end else begin
        t <= t + 5'h01;
      end
    end
  end
endmodule // remote_node

// ---- tb/tb.sv ----
// self-checking bench for the serial transceiver
`timescale 1ns/1ps
module tb;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [31:0] pwdata = 32'h0;
  reg         cpu_wait = 1'b0;
  reg         go = 1'b0;
  reg  [7:0]  ch = 8'h00;
  wire [31:0] prdata;
  wire        pready, pslverr, tx_out, tx_oe, line;
  wire        tx_in = tx_oe ? tx_out : line;
  reg  [31:0] rd;
  reg  [15:0] lfsr = 16'h0016;
  reg  [8:0]  got, v, q [0:2];
  reg         err_s, stopb;
  integer     err_count = 0, cmp_count = 0, i, j;
  always #4 pclk = ~pclk;
  // transmit-line monitor, samples each data bit and the stop bit in its middle
  reg         mon_busy = 1'b0;
  reg  [9:0]  mon_sh = 10'h000;
  reg  [9:0]  mon_q [0:15];
  integer     mon_c = 0, mon_nb = 8, mon_cnt = 0, taken = 0;
  always @(negedge pclk) begin
    if (!mon_busy) begin
      mon_c <= 0;
      mon_sh <= 10'h000;
      mon_busy <= (tx_out === 1'b0);
    end else begin
      mon_c <= mon_c + 1;
      if (mon_c % 16 == 7 && mon_c > 16) begin
        if (mon_c / 16 - 1 < mon_nb) begin
          mon_sh[mon_c / 16 - 1] <= tx_out;
        end else begin
          mon_q[mon_cnt % 16] <= {tx_out, mon_sh[8:0]};
          mon_cnt <= mon_cnt + 1;
          mon_busy <= 1'b0;
        end
      end
    end
  end
  uart_frame_loop_config dut_u (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_wait(cpu_wait), .rx_pin(line), .tx_in(tx_in), .tx_out(tx_out),
    .tx_oe(tx_oe));
  remote_node far_u (.pclk(pclk), .presetn(presetn), .go(go), .ch(ch),
    .line(line));
  function [15:0] nxt(input [15:0] s);
    nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [8:0] expch(input [8:0] d, input nine, input pe, input pt);
    begin
      expch = nine ? d : {1'b0, d[7:0]};
      if (pe && nine) expch[8] = ^d[7:0] ^ pt;
      if (pe && !nine) expch[7] = ^d[6:0] ^ pt;
    end
  endfunction
  task test_done;
    begin
      $display("checks %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task check(input [63:0] n, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("ERROR %0s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] wd);
    integer k;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 20) begin
        @(posedge pclk);
        k = k + 1;
      end
      rd = prdata;
      err_s = pslverr;
      if (k >= 20) begin
        err_count = err_count + 1;
        test_done;
      end
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // take the next frame captured by the line monitor
  task grab;
    integer k;
    begin
      k = 0;
      while (mon_cnt <= taken && k < 4000) begin
        @(negedge pclk);
        k = k + 1;
      end
      if (k >= 4000) begin
        err_count = err_count + 1;
        test_done;
      end
      got = mon_q[taken % 16][8:0];
      stopb = mon_q[taken % 16][9];
      taken = taken + 1;
    end
  endtask
  task rx(input [7:0] fr, input [7:0] dr, input hs, input [7:0] hc,
          input fs, input [7:0] fc, input [7:0] e);
    integer k;
    begin
      apb(1'b1, 8'h00, {24'h0, fr});
      apb(1'b1, 8'h14, {24'h0, dr});
      @(posedge pclk);
      go <= fs;
      ch <= fc;
      @(posedge pclk);
      go <= 1'b0;
      if (hs) apb(1'b1, 8'h08, {24'h0, hc});
      rd = 32'h0;
      k = 0;
      while (rd[2] !== 1'b1 && k < 100) begin
        apb(1'b0, 8'h0C, 32'h0);
        k = k + 1;
      end
      if (k >= 100) begin
        err_count = err_count + 1;
        test_done;
      end
      apb(1'b0, 8'h08, 32'h0);
      check("rxchar", {24'h0, e}, rd & 32'hFF);
    end
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    check("frame", 32'h0, rd);
    apb(1'b0, 8'h04, 32'h0);
    check("enable", 32'h0, rd);
    lfsr = nxt(lfsr);
    apb(1'b1, 8'h04, {24'h0, lfsr[7:2], 2'b00});
    apb(1'b0, 8'h04, 32'h0);
    check("enable", {24'h0, lfsr[7:2], 2'b00}, rd);
    apb(1'b0, 8'h18, 32'h0);
    check("slverr", 32'h1, {31'h0, err_s});
    apb(1'b1, 8'h04, 32'h0C);
    for (i = 0; i < 8; i = i + 1) begin
      apb(1'b1, 8'h00, {27'h0, i[2], 2'b00, i[1], i[0]});
      mon_nb = 8 + i[2];
      for (j = 0; j < 3; j = j + 1) begin
        lfsr = nxt(lfsr);
        q[j] = (i == 0) ? 9'h0FF : lfsr[8:0];
        apb(1'b1, 8'h08, {23'h0, q[j]});
      end
      if (i == 0) begin
        apb(1'b0, 8'h0C, 32'h0);
        check("txroom", 32'h0, rd & 32'h1);
        apb(1'b1, 8'h08, 32'h55);
      end
      for (j = 0; j < 3; j = j + 1) begin
        grab;
        check("txchar", expch(q[j], i[2], i[1], i[0]), got);
        check("stop", 32'h1, {31'h0, stopb});
      end
      repeat (24) @(posedge pclk);
      apb(1'b0, 8'h0C, 32'h0);
      check("txidle", 32'h2, rd & 32'h2);
    end
    mon_nb = 8;
    apb(1'b1, 8'h00, 32'h40);
    apb(1'b1, 8'h08, 32'hA5);
    cpu_wait <= 1'b1;
    repeat (3) @(negedge pclk);
    v[0] = tx_out;
    repeat (40) @(negedge pclk);
    check("frozen", {31'h0, v[0]}, {31'h0, tx_out});
    @(posedge pclk);
    cpu_wait <= 1'b0;
    grab;
    check("txwait", 32'hA5, got);
    lfsr = nxt(lfsr);
    rx(8'h20, 8'h00, 1'b1, ~lfsr[7:0], 1'b1, lfsr[7:0], lfsr[7:0]);
    rx(8'h80, 8'h00, 1'b1, lfsr[7:0], 1'b1, ~lfsr[7:0], lfsr[7:0]);
    rx(8'hA0, 8'h00, 1'b0, 8'h00, 1'b1, lfsr[7:0], lfsr[7:0]);
    check("oe", 32'h0, {31'h0, tx_oe});
    rx(8'hA0, 8'h01, 1'b1, ~lfsr[7:0], 1'b0, 8'h00, ~lfsr[7:0]);
    check("oe", 32'h1, {31'h0, tx_oe});
    apb(1'b1, 8'h0C, 32'h08);
    apb(1'b1, 8'h08, 32'h3C);
    repeat (400) @(posedge pclk);
    apb(1'b0, 8'h0C, 32'h0);
    check("idle", 32'hC, rd & 32'hC);
    apb(1'b0, 8'h08, 32'h0);
    check("rxwire", 32'h3C, rd);
    apb(1'b1, 8'h04, 32'h0E);
    rx(8'h08, 8'h00, 1'b0, 8'h00, 1'b1, 8'hC3, 8'hC3);
    apb(1'b0, 8'h04, 32'h0);
    check("woke", 32'h0C, rd);
    test_done;
  end
endmodule // tb

// ---- tb/uart_frame_loop_config_properties.sv ----
// port-level checks of the serial transceiver
`timescale 1ns/1ps
module uart_frame_loop_config_checker #(
  parameter ADDR_W = 8
) (
  input wire              pclk,
  input wire              presetn,
  input wire [ADDR_W-1:0] paddr,
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [31:0]       pwdata,
  input wire [31:0]       prdata,
  input wire              pready,
  input wire              pslverr,
  input wire              cpu_wait,
  input wire              tx_out,
  input wire              tx_oe
);
  reg  [7:0] frame;
  reg        te;
  reg        dir;
  wire       wr = psel && penable && pready && pwrite;
  wire       oe_exp = te && !(frame[7] && frame[5] && !dir);
  // shadows of the configuration written over the bus
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame <= 8'h00;
      te    <= 1'b0;
      dir   <= 1'b0;
    end else if (wr) begin
      if (paddr == 8'h00) frame <= pwdata[7:0];
      if (paddr == 8'h04) te <= pwdata[3];
      if (paddr == 8'h14) dir <= pwdata[0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_pready_after_setup: assert property (
    psel && !penable ##1 psel && penable |=> pready)
    else $error("no answer one cycle into access phase");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside an answer");
  a_err_addr_decode: assert property (
    pready |-> pslverr == !(paddr == 8'h00 || paddr == 8'h04 ||
      paddr == 8'h08 || paddr == 8'h0C || paddr == 8'h10 ||
      paddr == 8'h14))
    else $error("pslverr does not match the address map");
  a_wait_freeze: assert property (
    cpu_wait && $past(cpu_wait) && frame[6] && $past(frame[6])
    |-> $stable(tx_out))
    else $error("tx line moved while frozen in wait");
  a_oe_direction: assert property (
    oe_exp == $past(oe_exp) |-> tx_oe == oe_exp)
    else $error("tx pin enable wrong for the routing");
  a_tx_off_idle: assert property (!te && !$past(te) |-> tx_out)
    else $error("tx line low with transmitter off");
  a_start_bit_hold: assert property ($fell(tx_out) |-> !tx_out [*8])
    else $error("start bit shorter than half a bit");
endmodule // uart_frame_loop_config_checker
bind uart_frame_loop_config uart_frame_loop_config_checker #(
  .ADDR_W(ADDR_W)) chk_u (.pclk(pclk), .presetn(presetn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cpu_wait(cpu_wait), .tx_out(tx_out), .tx_oe(tx_oe));
